// ===== verilog/tcc_timer16_consts.svh
// Constants of the 16-bit capture/compare timer: APB offsets, reset values, codes.
// Assumes inclusion by bare name from the package and the timer module.
`ifndef TCC_TIMER16_CONSTS_SVH
`define TCC_TIMER16_CONSTS_SVH
`define TCC_OFS_CTRL_ONE 8'h00
`define TCC_OFS_CTRL_TWO 8'h04
`define TCC_OFS_STATUS 8'h08
`define TCC_OFS_CNT_HIGH 8'h0C
`define TCC_OFS_CNT_LOW 8'h10
`define TCC_OFS_ALT_HIGH 8'h14
`define TCC_OFS_ALT_LOW 8'h18
`define TCC_OFS_CAP1_HIGH 8'h1C
`define TCC_OFS_CAP1_LOW 8'h20
`define TCC_OFS_CAP2_HIGH 8'h24
`define TCC_OFS_CAP2_LOW 8'h28
`define TCC_OFS_CMP1_HIGH 8'h2C
`define TCC_OFS_CMP1_LOW 8'h30
`define TCC_OFS_CMP2_HIGH 8'h34
`define TCC_OFS_CMP2_LOW 8'h38
`define TCC_CNT_RESTART 16'hFFFC
`define TCC_CNT_MAX 16'hFFFF
`define TCC_CMP_RESET 16'h8000
`define TCC_CAP_RESET 16'h0000
`define TCC_CTRL_RESET 8'h00
`define TCC_SEL_DIV4 2'h0
`define TCC_SEL_DIV8 2'h1
`define TCC_SEL_DIV2 2'h2
`define TCC_SEL_EXT 2'h3
`define TCC_PRE_DIV2 3'h1
`define TCC_PRE_DIV4 3'h3
`define TCC_PRE_DIV8 3'h7
`define TCC_PRE_RESET 3'h0
`endif

// ===== verilog/tcc_pkg.sv
// Types of the 16-bit capture/compare timer: control and status layouts.
// Assumes the constants header is on the include path.
`default_nettype none
`include "tcc_timer16_consts.svh"
package tcc_pkg;
	typedef struct packed {
		logic overflow_irq_enable;
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic [1:0] compare_level;
		logic [1:0] capture_edge_select;
		logic spare;
	} tcc_ctrl_one_t;
	typedef struct packed {
		logic [2:0] spare;
		logic [1:0] compare_pin_enable;
		logic ext_clock_edge_select;
		logic [1:0] clock_select_bits;
	} tcc_ctrl_two_t;
	typedef struct packed {
		logic [2:0] spare;
		logic [1:0] compare_flag;
		logic [1:0] capture_flag;
		logic overflow_flag;
	} tcc_status_t;
endpackage
`default_nettype wire

// ===== verilog/tcc_timer16.sv
// 16-bit free-running timer with two capture and two compare channels, APB slave.
// Assumes pins synchronous-safe after the two-stage synchronisers, one clock pclk.
//
// How it works
// - High byte read freezes low byte until low read
// - Lone low read returns live count byte
// - Wrap FFFF to 0000 sets overflow flag
// - Overflow interrupt needs enable and clear mask
// - Overflow clears on status read then low access
// - Alternate low access never clears overflow
// - WAIT runs on, HALT freezes the count
// - Clock-select 11 picks external input, edge selectable
// - External edges synchronised, source spaces them four clocks
// - Capture pin edge copies count into register
// - Capture sets flag, interrupt when enabled, unmasked
// - Capture flag clears on status read, low access
// - Capture high read blocks transfers until low read
// - Capture pins always watched, only the edge chosen by capture_edge_select counts
// - Compare each timer step, match sets flag, interrupt
// - Compare registers software only, reset to 8000
// - Enabled match drives level; pin low from reset
// - Disabled pin gets no level; flag still works
// - Compare flag clears on status read, low access
// - Compare high write inhibits until low written
// - Divide-by-2 matches equal, others match plus one
// - Prescaler divides pclk by 2, 4 or 8
// - Counter low writes reload restart value
`timescale 1ns/100ps
`default_nettype none
`include "tcc_timer16_consts.svh"
module tcc_timer16 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	input wire logic wait_mode,
	input wire logic ext_count_input,
	input wire logic [1:0] capture_pin,
	output logic [1:0] compare_pin,
	output logic [1:0] compare_pin_oe,
	output logic timer_irq
);
	tcc_pkg::tcc_ctrl_one_t ctrl_one_q;
	tcc_pkg::tcc_ctrl_two_t ctrl_two_q;
	logic [15:0] cnt_q;
	logic [2:0] pre_q;
	logic [2:0] pre_max;
	logic tick;
	logic tick_seen_q;
	logic reload;
	logic ext_neg_q;
	logic [2:0] ext_sync_q;
	logic [31:0] rdata;
	logic rd_ok;
	logic rd_ev;
	logic wr_ev;
	logic acc_ev;
	logic [7:0] cnt_latch_q;
	logic cnt_lock_q;
	logic ovf_q;
	logic ovf_arm_q;
	logic ovf_set;
	logic [15:0] cap_q [2];
	logic cap_flag_q [2];
	logic cap_arm_q [2];
	logic cap_lock_q [2];
	logic cap_ev [2];
	logic [15:0] cmp_q [2];
	logic cmp_flag_q [2];
	logic cmp_arm_q [2];
	logic cmp_inh_q [2];
	logic cmp_ev [2];
	logic [2:0] cap_sync_q [2];
	logic [7:0] cap_hi_ofs [2];
	logic [7:0] cap_lo_ofs [2];
	logic [7:0] cmp_hi_ofs [2];
	logic [7:0] cmp_lo_ofs [2];
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic irq_q;
	logic [1:0] pin_q;
	logic [1:0] pin_oe_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	assign cap_hi_ofs[0] = `TCC_OFS_CAP1_HIGH;
	assign cap_hi_ofs[1] = `TCC_OFS_CAP2_HIGH;
	assign cap_lo_ofs[0] = `TCC_OFS_CAP1_LOW;
	assign cap_lo_ofs[1] = `TCC_OFS_CAP2_LOW;
	assign cmp_hi_ofs[0] = `TCC_OFS_CMP1_HIGH;
	assign cmp_hi_ofs[1] = `TCC_OFS_CMP2_HIGH;
	assign cmp_lo_ofs[0] = `TCC_OFS_CMP1_LOW;
	assign cmp_lo_ofs[1] = `TCC_OFS_CMP2_LOW;

	// Reads act in the wait cycle so data and latching see the same count
	assign rd_ev = psel & penable & ~pready_q & ~pwrite;
	assign wr_ev = psel & penable & pready_q & pwrite;
	assign acc_ev = rd_ev | wr_ev;

	// Prescaler and clock selection
	always_comb begin
		case (ctrl_two_q.clock_select_bits)
			`TCC_SEL_DIV2: pre_max = `TCC_PRE_DIV2;
			`TCC_SEL_DIV4: pre_max = `TCC_PRE_DIV4;
			`TCC_SEL_DIV8: pre_max = `TCC_PRE_DIV8;
			default: pre_max = `TCC_PRE_DIV2;
		endcase
	end

	// Pin caught on the falling edge; costs half a cycle of settling margin
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_neg_q <= 1'b0;
		end else begin
			ext_neg_q <= ext_count_input;
		end
	end

	// Only stages 1 and 2 feed the edge detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_q <= 3'h0;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], ext_neg_q};
		end
	end

	always_comb begin
		if (halt_mode) begin
			tick = 1'b0;
		end else if (ctrl_two_q.clock_select_bits == `TCC_SEL_EXT) begin
			tick = ctrl_two_q.ext_clock_edge_select ? (ext_sync_q[1] & ~ext_sync_q[2])
				: (~ext_sync_q[1] & ext_sync_q[2]);
		end else begin
			tick = (pre_q == pre_max);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= `TCC_PRE_RESET;
		end else if (reload || ctrl_two_q.clock_select_bits == `TCC_SEL_EXT) begin
			pre_q <= `TCC_PRE_RESET;
		end else if (!halt_mode) begin
			pre_q <= (pre_q == pre_max) ? `TCC_PRE_RESET : pre_q + 3'h1;
		end
	end

	// Free-running counter; wait_mode deliberately has no effect
	assign reload = wr_ev & ((paddr == `TCC_OFS_CNT_LOW) | (paddr == `TCC_OFS_ALT_LOW));
	assign ovf_set = tick & ~reload & (cnt_q == `TCC_CNT_MAX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= `TCC_CNT_RESTART;
			tick_seen_q <= 1'b0;
		end else begin
			tick_seen_q <= tick & ~reload;
			if (reload) begin
				cnt_q <= `TCC_CNT_RESTART;
			end else if (tick) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// Two-byte counter read latch, shared by both register pairs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_latch_q <= 8'h00;
			cnt_lock_q <= 1'b0;
		end else if (rd_ev && (paddr == `TCC_OFS_CNT_HIGH || paddr == `TCC_OFS_ALT_HIGH)) begin
			if (!cnt_lock_q) begin
				cnt_latch_q <= cnt_q[7:0];
			end
			cnt_lock_q <= 1'b1;
		end else if (rd_ev && (paddr == `TCC_OFS_CNT_LOW || paddr == `TCC_OFS_ALT_LOW)) begin
			cnt_lock_q <= 1'b0;
		end
	end

	// Overflow flag: set wins over the two-step clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
			ovf_arm_q <= 1'b0;
		end else begin
			if (ovf_set) begin
				ovf_q <= 1'b1;
			end else if (ovf_arm_q && acc_ev && paddr == `TCC_OFS_CNT_LOW) begin
				ovf_q <= 1'b0;
			end
			if (ovf_arm_q && acc_ev && paddr == `TCC_OFS_CNT_LOW) begin
				ovf_arm_q <= 1'b0;
			end else if (rd_ev && paddr == `TCC_OFS_STATUS && ovf_q) begin
				ovf_arm_q <= 1'b1;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			// Capture path: pin transitions always reach the detector
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cap_sync_q[gi] <= 3'h0;
				end else begin
					cap_sync_q[gi] <= {cap_sync_q[gi][1:0], capture_pin[gi]};
				end
			end
			assign cap_ev[gi] = ctrl_one_q.capture_edge_select[gi] ?
				(cap_sync_q[gi][1] & ~cap_sync_q[gi][2]) : (~cap_sync_q[gi][1] & cap_sync_q[gi][2]);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cap_q[gi] <= `TCC_CAP_RESET;
					cap_lock_q[gi] <= 1'b0;
				end else begin
					if (cap_ev[gi] && !cap_lock_q[gi]) begin
						cap_q[gi] <= cnt_q;
					end
					if (rd_ev && paddr == cap_hi_ofs[gi]) begin
						cap_lock_q[gi] <= 1'b1;
					end else if (rd_ev && paddr == cap_lo_ofs[gi]) begin
						cap_lock_q[gi] <= 1'b0;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cap_flag_q[gi] <= 1'b0;
					cap_arm_q[gi] <= 1'b0;
				end else begin
					if (cap_ev[gi]) begin
						cap_flag_q[gi] <= 1'b1;
					end else if (cap_arm_q[gi] && acc_ev && paddr == cap_lo_ofs[gi]) begin
						cap_flag_q[gi] <= 1'b0;
					end
					if (cap_arm_q[gi] && acc_ev && paddr == cap_lo_ofs[gi]) begin
						cap_arm_q[gi] <= 1'b0;
					end else if (rd_ev && paddr == `TCC_OFS_STATUS && cap_flag_q[gi]) begin
						cap_arm_q[gi] <= 1'b1;
					end
				end
			end

			// Compare path: one test per counter step, target shifted by prescale
			assign cmp_ev[gi] = tick_seen_q & ~cmp_inh_q[gi] & (cnt_q == ((ctrl_two_q.clock_select_bits ==
				`TCC_SEL_DIV2) ? cmp_q[gi] : cmp_q[gi] + 16'h0001));

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_q[gi] <= `TCC_CMP_RESET;
					cmp_inh_q[gi] <= 1'b0;
				end else if (wr_ev && paddr == cmp_hi_ofs[gi]) begin
					cmp_q[gi][15:8] <= pwdata[7:0];
					cmp_inh_q[gi] <= 1'b1;
				end else if (wr_ev && paddr == cmp_lo_ofs[gi]) begin
					cmp_q[gi][7:0] <= pwdata[7:0];
					cmp_inh_q[gi] <= 1'b0;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_flag_q[gi] <= 1'b0;
					cmp_arm_q[gi] <= 1'b0;
				end else begin
					if (cmp_ev[gi]) begin
						cmp_flag_q[gi] <= 1'b1;
					end else if (cmp_arm_q[gi] && acc_ev && paddr == cmp_lo_ofs[gi]) begin
						cmp_flag_q[gi] <= 1'b0;
					end
					if (cmp_arm_q[gi] && acc_ev && paddr == cmp_lo_ofs[gi]) begin
						cmp_arm_q[gi] <= 1'b0;
					end else if (rd_ev && paddr == `TCC_OFS_STATUS && cmp_flag_q[gi]) begin
						cmp_arm_q[gi] <= 1'b1;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_q[gi] <= 1'b0;
					pin_oe_q[gi] <= 1'b0;
				end else begin
					pin_oe_q[gi] <= ctrl_two_q.compare_pin_enable[gi];
					if (cmp_ev[gi] && ctrl_two_q.compare_pin_enable[gi]) begin
						pin_q[gi] <= ctrl_one_q.compare_level[gi];
					end
				end
			end

			property p_cmp_sw_only;
				!wr_ev |=> $stable(cmp_q[gi]);
			endproperty
			a_cmp_sw_only: assert property (p_cmp_sw_only) else $error("compare register changed without a write");
			property p_pin_level;
				(cmp_ev[gi] && ctrl_two_q.compare_pin_enable[gi]) |=> (pin_q[gi] == $past(ctrl_one_q.compare_level[gi]));
			endproperty
			a_pin_level: assert property (p_pin_level) else $error("compare pin missed its level");
			property p_cap_load;
				(cap_ev[gi] && !cap_lock_q[gi]) |=> (cap_q[gi] == $past(cnt_q));
			endproperty
			a_cap_load: assert property (p_cap_load) else $error("capture value not loaded");
			property p_cap_hold;
				(cap_lock_q[gi] && !(rd_ev && paddr == cap_lo_ofs[gi])) |=> $stable(cap_q[gi]);
			endproperty
			a_cap_hold: assert property (p_cap_hold) else $error("capture moved while blocked");
			property p_pin_off;
				!ctrl_two_q.compare_pin_enable[gi] |=> (!pin_oe_q[gi] && $stable(pin_q[gi]));
			endproperty
			a_pin_off: assert property (p_pin_off) else $error("disabled compare pin changed");
		end
	endgenerate

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one_q <= `TCC_CTRL_RESET;
			ctrl_two_q <= `TCC_CTRL_RESET;
		end else if (wr_ev && paddr == `TCC_OFS_CTRL_ONE) begin
			ctrl_one_q <= pwdata[7:0];
		end else if (wr_ev && paddr == `TCC_OFS_CTRL_TWO) begin
			ctrl_two_q <= pwdata[7:0];
		end
	end

	// Read mux; unmapped offsets answer with an error
	always_comb begin
		rdata = 32'h00000000;
		rd_ok = 1'b1;
		case (paddr)
			`TCC_OFS_CTRL_ONE: rdata[7:0] = ctrl_one_q;
			`TCC_OFS_CTRL_TWO: rdata[7:0] = ctrl_two_q;
			`TCC_OFS_STATUS: rdata[4:0] = {cmp_flag_q[1], cmp_flag_q[0], cap_flag_q[1], cap_flag_q[0], ovf_q};
			`TCC_OFS_CNT_HIGH, `TCC_OFS_ALT_HIGH: rdata[7:0] = cnt_q[15:8];
			`TCC_OFS_CNT_LOW, `TCC_OFS_ALT_LOW: rdata[7:0] = cnt_lock_q ? cnt_latch_q : cnt_q[7:0];
			`TCC_OFS_CAP1_HIGH: rdata[7:0] = cap_q[0][15:8];
			`TCC_OFS_CAP1_LOW: rdata[7:0] = cap_q[0][7:0];
			`TCC_OFS_CAP2_HIGH: rdata[7:0] = cap_q[1][15:8];
			`TCC_OFS_CAP2_LOW: rdata[7:0] = cap_q[1][7:0];
			`TCC_OFS_CMP1_HIGH: rdata[7:0] = cmp_q[0][15:8];
			`TCC_OFS_CMP1_LOW: rdata[7:0] = cmp_q[0][7:0];
			`TCC_OFS_CMP2_HIGH: rdata[7:0] = cmp_q[1][15:8];
			`TCC_OFS_CMP2_LOW: rdata[7:0] = cmp_q[1][7:0];
			default: rd_ok = 1'b0;
		endcase
	end

	// One wait state so read data leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else if (psel && penable && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= ~rd_ok;
			prdata_q <= pwrite ? 32'h00000000 : rdata;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Pending requests stay in the flags; the mask only gates the line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ~cpu_irq_mask & ((ovf_q & ctrl_one_q.overflow_irq_enable)
				| ((cap_flag_q[0] | cap_flag_q[1]) & ctrl_one_q.capture_irq_enable)
				| ((cmp_flag_q[0] | cmp_flag_q[1]) & ctrl_one_q.compare_irq_enable));
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign timer_irq = irq_q;
	assign compare_pin = pin_q;
	assign compare_pin_oe = pin_oe_q;

	property p_ovf_set;
		ovf_set |=> ovf_q ##0 (cnt_q == 16'h0000);
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("wrap did not set overflow");
	property p_irq_mask;
		cpu_irq_mask |=> !timer_irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("interrupt raised while masked");
	property p_ovf_clear;
		$fell(ovf_q) |-> $past(ovf_arm_q && acc_ev && paddr == `TCC_OFS_CNT_LOW);
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow cleared without sequence");
	property p_alt_keep;
		(ovf_q && acc_ev && paddr == `TCC_OFS_ALT_LOW) |=> ovf_q;
	endproperty
	a_alt_keep: assert property (p_alt_keep) else $error("alternate access cleared overflow");
	property p_halt;
		(halt_mode && !reload) |=> $stable(cnt_q);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved in halt");
	property p_latch;
		(cnt_lock_q && !(rd_ev && (paddr == `TCC_OFS_CNT_LOW || paddr == `TCC_OFS_ALT_LOW)))
			|=> $stable(cnt_latch_q) && cnt_lock_q;
	endproperty
	a_latch: assert property (p_latch) else $error("counter low latch not frozen");
	property p_reload;
		reload |=> (cnt_q == `TCC_CNT_RESTART);
	endproperty
	a_reload: assert property (p_reload) else $error("counter not reloaded");
	property p_div2;
		(ctrl_two_q.clock_select_bits == `TCC_SEL_DIV2 && !halt_mode && !reload && $past(tick) && !$past(reload))
			|-> !tick;
	endproperty
	a_div2: assert property (p_div2) else $error("divide-by-2 ticked twice in a row");
	c_ovf: cover property (ovf_set ##[1:40] (ovf_arm_q && acc_ev && paddr == `TCC_OFS_CNT_LOW));
	c_cap: cover property (cap_ev[0] && !cap_lock_q[0]);
	c_cmp: cover property (cmp_ev[1] && ctrl_two_q.compare_pin_enable[1]);
	c_irq: cover property (timer_irq && cmp_flag_q[0]);
endmodule
`default_nettype wire

// ===== test/tcc_pins_model.sv
// Pin-side partner: capture inputs and external count clock.
// Assumes the bench requests each external pulse and sets capture levels.
`timescale 1ns/100ps
`default_nettype none
module tcc_pins_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ext_req,
	input wire logic [1:0] cap_lvl,
	output logic ext_count_input,
	output logic [1:0] capture_pin,
	output logic ext_busy
);
	logic [3:0] tick_q;
	// Wired straight through, as the pins are always connected
	assign capture_pin = cap_lvl;
	assign ext_busy = tick_q != 4'h0;
	// Four cycles high, then at least four low: active edges stay spaced
	assign ext_count_input = tick_q > 4'h4;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q <= 4'h0;
		end else if (ext_req && !ext_busy) begin
			tick_q <= 4'h8;
		end else if (ext_busy) begin
			tick_q <= tick_q - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ===== test/tcc_timer16_tb.sv
// Self-checking bench of the capture/compare timer over APB.
// Assumes the constants header on the include path and the pin model.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_timer16_consts.svh"
module tcc_timer16_tb;
	typedef struct packed {logic [7:0] addr; logic [7:0] exp;} tcc_tb_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, timer_irq, ext_count_input, ext_busy, slv_err;
	logic cpu_irq_mask = 1'b0, halt_mode = 1'b1, wait_mode = 1'b0, ext_req = 1'b0;
	logic [1:0] cap_lvl = 2'b10, capture_pin, compare_pin, compare_pin_oe;
	logic [1:0] sel_v [3] = '{`TCC_SEL_DIV2, `TCC_SEL_DIV4, `TCC_SEL_DIV8};
	tcc_tb_row_t rows [11] = '{'{`TCC_OFS_CTRL_ONE, 8'h00}, '{`TCC_OFS_CTRL_TWO, 8'h00},
		'{`TCC_OFS_STATUS, 8'h00}, '{`TCC_OFS_CNT_HIGH, 8'hFF}, '{`TCC_OFS_CNT_LOW, 8'hFC},
		'{`TCC_OFS_CMP1_HIGH, 8'h80}, '{`TCC_OFS_CMP1_LOW, 8'h00}, '{`TCC_OFS_CMP2_HIGH, 8'h80},
		'{`TCC_OFS_CMP2_LOW, 8'h00}, '{`TCC_OFS_CAP1_HIGH, 8'h00}, '{`TCC_OFS_CAP1_LOW, 8'h00}};
	int err_count = 0, compares = 0, n;
	always #10 pclk = ~pclk;
	tcc_timer16 u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .wait_mode(wait_mode),
		.ext_count_input(ext_count_input), .capture_pin(capture_pin), .compare_pin(compare_pin),
		.compare_pin_oe(compare_pin_oe), .timer_irq(timer_irq));
	tcc_pins_model u_pins (.pclk(pclk), .presetn(presetn), .ext_req(ext_req), .cap_lvl(cap_lvl),
		.ext_count_input(ext_count_input), .capture_pin(capture_pin), .ext_busy(ext_busy));
	task automatic close_out();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// Request held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		tick(1);
		penable <= 1'b1;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			err_count++;
			close_out();
		end
		q = prdata[7:0];
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		apb(1'b0, a, 8'h00, q);
		check(q, e);
	endtask
	// m full pulses on the external input, each followed by time for synchronising
	task automatic step(input int m);
		int k;
		repeat (m) begin
			ext_req <= 1'b1;
			tick(1);
			ext_req <= 1'b0;
			tick(1);
			k = 0;
			while (ext_busy !== 1'b0 && k < 20) begin
				tick(1);
				k++;
			end
			check(8'(k < 20), 8'h01);
			tick(4);
		end
	endtask
	initial begin
		tick(16);
		presetn <= 1'b1;
		tick(1);
		// Counter held in HALT so reset values stay put
		for (int i = 0; i < 11; i++) begin
			rd(rows[i].addr, rows[i].exp);
		end
		tick(30);
		rd(`TCC_OFS_CNT_LOW, 8'hFC);
		rd(8'h3C, 8'h00);
		check(8'(slv_err), 8'h01);
		check(8'(compare_pin), 8'h00);
		$display("done: reset values");
		halt_mode <= 1'b0;
		wait_mode <= 1'b1;
		wr(`TCC_OFS_CTRL_ONE, 8'h80);
		for (int i = 0; i < 3; i++) begin
			wr(`TCC_OFS_CTRL_TWO, {6'h0, sel_v[i]});
			rd(`TCC_OFS_STATUS, (i == 0) ? 8'h00 : 8'h01);
			wr(`TCC_OFS_CNT_LOW, 8'h00);
			tick(1);
			n = 2;
			while (timer_irq !== 1'b1 && n < 200) begin
				tick(1);
				n++;
			end
			check(8'(n >= 6 << i && n <= (8 << i) + 4), 8'h01);
		end
		$display("done: prescaler");
		wr(`TCC_OFS_CTRL_TWO, 8'h07);
		wr(`TCC_OFS_CTRL_ONE, 8'h00);
		tick(2);
		check(8'(timer_irq), 8'h00);
		cpu_irq_mask <= 1'b1;
		wr(`TCC_OFS_CTRL_ONE, 8'h80);
		tick(2);
		check(8'(timer_irq), 8'h00);
		cpu_irq_mask <= 1'b0;
		tick(2);
		check(8'(timer_irq), 8'h01);
		rd(`TCC_OFS_STATUS, 8'h01);
		wr(`TCC_OFS_ALT_LOW, 8'h00);
		rd(`TCC_OFS_STATUS, 8'h01);
		rd(`TCC_OFS_CNT_LOW, 8'hFC);
		rd(`TCC_OFS_STATUS, 8'h00);
		wr(`TCC_OFS_CTRL_ONE, 8'h00);
		rd(`TCC_OFS_CNT_HIGH, 8'hFF);
		step(2);
		rd(`TCC_OFS_CNT_HIGH, 8'hFF);
		rd(`TCC_OFS_CNT_LOW, 8'hFC);
		rd(`TCC_OFS_CNT_LOW, 8'hFE);
		step(2);
		rd(`TCC_OFS_STATUS, 8'h01);
		$display("done: counter");
		wr(`TCC_OFS_CNT_LOW, 8'h00);
		wr(`TCC_OFS_CTRL_ONE, 8'h42);
		cap_lvl <= 2'b11;
		tick(6);
		check(8'(timer_irq), 8'h01);
		rd(`TCC_OFS_STATUS, 8'h02);
		rd(`TCC_OFS_CAP1_HIGH, 8'hFF);
		step(1);
		cap_lvl <= 2'b10;
		tick(4);
		cap_lvl <= 2'b11;
		tick(6);
		rd(`TCC_OFS_CAP1_LOW, 8'hFC);
		rd(`TCC_OFS_STATUS, 8'h00);
		check(8'(timer_irq), 8'h00);
		cap_lvl <= 2'b10;
		tick(4);
		cap_lvl <= 2'b11;
		tick(6);
		rd(`TCC_OFS_CAP1_HIGH, 8'hFF);
		rd(`TCC_OFS_CAP1_LOW, 8'hFD);
		cap_lvl <= 2'b01;
		tick(6);
		rd(`TCC_OFS_STATUS, 8'h06);
		$display("done: capture");
		wr(`TCC_OFS_CTRL_ONE, 8'h38);
		wr(`TCC_OFS_CTRL_TWO, 8'h0F);
		wr(`TCC_OFS_CMP1_HIGH, 8'hFF);
		wr(`TCC_OFS_CMP1_LOW, 8'hFE);
		wr(`TCC_OFS_CMP2_HIGH, 8'hFF);
		wr(`TCC_OFS_CMP2_LOW, 8'hFE);
		step(1);
		rd(`TCC_OFS_STATUS, 8'h06);
		check(8'(compare_pin), 8'h00);
		step(1);
		rd(`TCC_OFS_STATUS, 8'h1E);
		check(8'(compare_pin), 8'h01);
		check(8'(compare_pin_oe), 8'h01);
		check(8'(timer_irq), 8'h01);
		rd(`TCC_OFS_CMP1_HIGH, 8'hFF);
		wr(`TCC_OFS_CMP1_LOW, 8'hFE);
		rd(`TCC_OFS_STATUS, 8'h16);
		wr(`TCC_OFS_CMP2_HIGH, 8'h00);
		wr(`TCC_OFS_CMP2_LOW, 8'h01);
		wr(`TCC_OFS_CMP2_HIGH, 8'h00);
		step(3);
		rd(`TCC_OFS_STATUS, 8'h07);
		$display("done: compare");
		presetn <= 1'b0;
		halt_mode <= 1'b1;
		tick(2);
		check(8'(compare_pin), 8'h00);
		presetn <= 1'b1;
		tick(1);
		rd(`TCC_OFS_CMP1_HIGH, 8'h80);
		rd(`TCC_OFS_CTRL_TWO, 8'h00);
		rd(`TCC_OFS_CNT_LOW, 8'hFC);
		$display("done: second reset");
		// Falling external edge, then divide-by-2 compare with the count frozen on the match
		wr(`TCC_OFS_CTRL_TWO, 8'h03);
		halt_mode <= 1'b0;
		step(1);
		rd(`TCC_OFS_CNT_HIGH, 8'hFF);
		rd(`TCC_OFS_CNT_LOW, 8'hFD);
		wr(`TCC_OFS_CMP1_HIGH, 8'hFF);
		wr(`TCC_OFS_CMP1_LOW, 8'hFF);
		step(1);
		halt_mode <= 1'b1;
		wr(`TCC_OFS_CTRL_TWO, 8'h02);
		halt_mode <= 1'b0;
		tick(2);
		halt_mode <= 1'b1;
		rd(`TCC_OFS_STATUS, 8'h08);
		rd(`TCC_OFS_CNT_LOW, 8'hFF);
		$display("done: falling edge and divide-by-2");
		close_out();
	end
endmodule
`default_nettype wire
